// ### verilog/rsq_sequencer.sv
// System reset sequencer: gathers reset requests, stretches internal reset.
// Assumes comparator outputs and the reset pin are asynchronous levels;
// clk runs at 50 MHz and is the delay counter's clock.
`timescale 1ns/1ns
`default_nettype none
`include "rsq_regs.svh"

module rsq_sequencer
  import rsq_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       supply_low,
  input  wire logic       brownout_low,
  input  wire logic [2:0] brownout_level_select,
  input  wire logic       reset_pin,
  input  wire logic       pin_reset_enable,
  input  wire logic       watchdog_expire,
  input  wire logic       watchdog_enable,
  input  wire logic [1:0] startup_time_select,
  input  wire logic [3:0] clock_source_select,
  input  wire rsq_bus_t   bus,
  output logic      [7:0] rdata,
  output logic            core_reset,
  output logic            port_reset
);

  rsq_state_t  state;
  logic [1:0]  sync_por;
  logic [1:0]  sync_bod;
  logic [1:0]  sync_pin;
  logic [7:0]  bod_cnt;
  logic [7:0]  pin_cnt;
  logic        bod_hit;
  logic        pin_hit;
  logic        wdt_hit;
  logic        bod_on;
  logic        req;
  logic [19:0] stretch_cnt;
  logic [19:0] stretch_len;
  rsq_cause_t  cause;

  // Brown-out only active for non-disable codes
  assign bod_on = (brownout_level_select != `RSQ_BOD_OFF);

  // Port pins go to reset state combinationally for supply, brown-out and pin; watchdog reaches them only via the clocked core_reset
  assign port_reset = supply_low
                    | (bod_on & brownout_low)
                    | (pin_reset_enable & ~reset_pin)
                    | core_reset;

  // Two-stage synchronisers; first stage feeds the second only
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sync_por <= 2'h3;
      sync_bod <= 2'h0;
      sync_pin <= 2'h3;
    end
    else
    begin
      sync_por <= {sync_por[0], supply_low};
      sync_bod <= {sync_bod[0], brownout_low};
      sync_pin <= {sync_pin[0], reset_pin};
    end
  end

  // Brown-out glitch filter; dips shorter than the minimum are dropped
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      bod_cnt <= 8'h00;
    else if (!(sync_bod[1] && bod_on))
      bod_cnt <= 8'h00;
    else if (bod_cnt != 8'(`RSQ_BOD_MIN_CYC))
      bod_cnt <= bod_cnt + 8'h01;
  end
  assign bod_hit = (bod_cnt == 8'(`RSQ_BOD_MIN_CYC));

  // Pin width filter, clocked view of the pin for cause logging
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pin_cnt <= 8'h00;
    else if (!(pin_reset_enable && !sync_pin[1]))
      pin_cnt <= 8'h00;
    else if (pin_cnt != `RSQ_PIN_MIN_CYC)
      pin_cnt <= pin_cnt + 8'h01;
  end
  assign pin_hit = (pin_cnt == `RSQ_PIN_MIN_CYC);

  // Watchdog pulse is one cycle from same-domain logic
  assign wdt_hit = watchdog_expire & watchdog_enable;

  // OR of every source; any of them restarts the stretch
  assign req = sync_por[1] | bod_hit | pin_hit | wdt_hit;

  // Stretch length by fuses; larger selects give slower-settling clocks, but clock source 0 always gets the short stretch
  always_comb
  begin
    unique case (startup_time_select)
      2'h0:    stretch_len = `RSQ_STRETCH_SHORT;
      2'h1:    stretch_len = `RSQ_STRETCH_MID;
      default: stretch_len = `RSQ_STRETCH_LONG;
    endcase
    if (clock_source_select == 4'h0)
      stretch_len = `RSQ_STRETCH_SHORT;
  end

  // Sequencer; counter reloads on any request, so no partial stretch
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state       <= RSQ_HOLD;
      stretch_cnt <= 20'h00000;
    end
    else if (req)
    begin
      state       <= RSQ_HOLD;
      stretch_cnt <= 20'h00000;
    end
    else
    begin
      unique case (state)
        RSQ_HOLD:
        begin
          state       <= RSQ_STRETCH;
          stretch_cnt <= 20'h00000;
        end
        RSQ_STRETCH:
        begin
          if (stretch_cnt == stretch_len - 20'h00001)
            state <= RSQ_RUN;
          stretch_cnt <= stretch_cnt + 20'h00001;
        end
        RSQ_RUN: state <= RSQ_RUN;
        default: state <= RSQ_HOLD;
      endcase
    end
  end

  // Core held in reset until run state; core restarts at vector on release
  assign core_reset = (state != RSQ_RUN);

  // Cause flags: set beats software clear, power-on wipes the others
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cause    <= '0;
    end
    else
    begin
      if (bus.wr && bus.addr == `RSQ_ADDR_CAUSE)
      begin
        cause.watchdog <= cause.watchdog & bus.wdata[`RSQ_BIT_WATCHDOG];
        cause.brownout <= cause.brownout & bus.wdata[`RSQ_BIT_BROWNOUT];
        cause.pin      <= cause.pin & bus.wdata[`RSQ_BIT_PIN];
        cause.poweron  <= cause.poweron & bus.wdata[`RSQ_BIT_POWERON];
      end
      if (sync_por[1])
      begin
        cause.watchdog <= 1'b0;
        cause.brownout <= 1'b0;
        cause.pin      <= 1'b0;
        cause.poweron  <= 1'b1;
      end
      else
      begin
        if (wdt_hit)
          cause.watchdog <= 1'b1;
        if (bod_hit)
          cause.brownout <= 1'b1;
        if (pin_hit)
          cause.pin <= 1'b1;
      end
    end
  end

  // Register read port, data one cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rdata <= 8'h00;
    else if (bus.rd)
    begin
      unique case (bus.addr)
        `RSQ_ADDR_CAUSE:  rdata <= {4'h0, cause};
        `RSQ_ADDR_STATUS: rdata <= {5'h00, bod_on, state};
        default:          rdata <= 8'h00;
      endcase
    end
    else
      rdata <= 8'h00;
  end

  // Checks
  sequence s_req_drop;
    $fell(req);
  endsequence

  property p_req_holds;
    @(posedge clk) disable iff (!rst_n) req |=> core_reset;
  endproperty
  a_req_holds: assert property (p_req_holds)
    else $error("core released during request");

  property p_stretch_min;
    @(posedge clk) disable iff (!rst_n)
      s_req_drop |-> core_reset [*8];
  endproperty
  a_stretch_min: assert property (p_stretch_min)
    else $error("stretch too short");

  property p_por_flag;
    @(posedge clk) disable iff (!rst_n)
      sync_por[1] |=> cause.poweron && !cause.pin && !cause.watchdog;
  endproperty
  a_por_flag: assert property (p_por_flag)
    else $error("power-on flag handling wrong");

  property p_wdt_flag;
    @(posedge clk) disable iff (!rst_n)
      wdt_hit && !sync_por[1] |=> cause.watchdog;
  endproperty
  a_wdt_flag: assert property (p_wdt_flag)
    else $error("watchdog flag not set");

  property p_bod_off;
    @(posedge clk) disable iff (!rst_n) !bod_on |-> !bod_hit;
  endproperty
  a_bod_off: assert property (p_bod_off)
    else $error("brown-out fired while disabled");

  property p_bod_filter;
    @(posedge clk) disable iff (!rst_n)
      $rose(sync_bod[1]) && bod_on |-> !bod_hit [*8];
  endproperty
  a_bod_filter: assert property (p_bod_filter)
    else $error("brown-out dip not filtered");

  property p_port_async;
    @(posedge clk) disable iff (!rst_n)
      supply_low |-> port_reset;
  endproperty
  a_port_async: assert property (p_port_async)
    else $error("port reset missing");

  property p_pin_release;
    @(posedge clk) disable iff (!rst_n)
      $fell(pin_hit) && !req |=> state == RSQ_STRETCH;
  endproperty
  a_pin_release: assert property (p_pin_release)
    else $error("stretch not started after pin");

  property p_wdt_hold;
    @(posedge clk) disable iff (!rst_n)
      wdt_hit |=> state == RSQ_HOLD;
  endproperty
  a_wdt_hold: assert property (p_wdt_hold)
    else $error("watchdog pulse did not hold reset");

  property p_pin_flag;
    @(posedge clk) disable iff (!rst_n)
      pin_hit && !sync_por[1] |=> cause.pin;
  endproperty
  a_pin_flag: assert property (p_pin_flag)
    else $error("pin flag not set");

  property p_bod_flag;
    @(posedge clk) disable iff (!rst_n)
      bod_hit && !sync_por[1] |=> cause.brownout;
  endproperty
  a_bod_flag: assert property (p_bod_flag)
    else $error("brown-out flag not set");

  property p_por_restart;
    @(posedge clk) disable iff (!rst_n)
      sync_por[1] |=> state == RSQ_HOLD;
  endproperty
  a_por_restart: assert property (p_por_restart)
    else $error("low supply did not reassert reset");

  property p_run_release;
    @(posedge clk) disable iff (!rst_n)
      state == RSQ_STRETCH && stretch_cnt == stretch_len - 20'h00001
        && !req |=> !core_reset;
  endproperty
  a_run_release: assert property (p_run_release)
    else $error("core not released at end of stretch");

  property p_port_pin;
    @(posedge clk) disable iff (!rst_n)
      pin_reset_enable && !reset_pin |-> port_reset;
  endproperty
  a_port_pin: assert property (p_port_pin)
    else $error("port reset missing for pin");

  property p_port_bod;
    @(posedge clk) disable iff (!rst_n)
      bod_on && brownout_low |-> port_reset;
  endproperty
  a_port_bod: assert property (p_port_bod)
    else $error("port reset missing for brown-out");

  property p_rdata_idle;
    @(posedge clk) disable iff (!rst_n)
      !bus.rd |=> rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside read slot");

  // Hold with no request left: the stretch must start from zero
  sequence s_hold_quiet;
    state == RSQ_HOLD && !req;
  endsequence

  property p_hold_start;
    @(posedge clk) disable iff (!rst_n)
      s_hold_quiet |=> state == RSQ_STRETCH && stretch_cnt == 20'h00000;
  endproperty
  a_hold_start: assert property (p_hold_start)
    else $error("stretch did not start from zero");

endmodule
`default_nettype wire

// ### verilog/rsq_regs.svh
// Constants for the reset sequencer: register offsets, fields, counts.
// Assumes a 50 MHz system clock; included by the design module only.
`ifndef RSQ_REGS_SVH
`define RSQ_REGS_SVH

`define RSQ_ADDR_CAUSE     4'h0
`define RSQ_ADDR_STATUS    4'h1
`define RSQ_BIT_POWERON    0
`define RSQ_BIT_PIN        1
`define RSQ_BIT_BROWNOUT   2
`define RSQ_BIT_WATCHDOG   3
`define RSQ_BOD_OFF        3'h7
`define RSQ_CLK_MHZ        50
`define RSQ_BOD_MIN_US     2
`define RSQ_BOD_MIN_CYC    (`RSQ_BOD_MIN_US * `RSQ_CLK_MHZ)
`define RSQ_PIN_MIN_CYC    8'h08
`define RSQ_STRETCH_SHORT  20'h00010
`define RSQ_STRETCH_MID    20'h01000
`define RSQ_STRETCH_LONG   20'h10000

`endif

// ### verilog/rsq_pkg.sv
// Types shared by the reset sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package rsq_pkg;
  typedef enum logic [1:0] {
    RSQ_HOLD    = 2'b00,
    RSQ_STRETCH = 2'b01,
    RSQ_RUN     = 2'b10
  } rsq_state_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rsq_bus_t;

  typedef struct packed {
    logic watchdog;
    logic brownout;
    logic pin;
    logic poweron;
  } rsq_cause_t;
endpackage

// ### bench/rsq_partner.sv
// Far side of the reset sequencer: supply monitors, reset pin, watchdog.
// Assumes the bench calls pulse() and that every change follows a rising edge.
`timescale 1ns/1ns
`default_nettype none

module rsq_partner
(
  input  wire logic clk,
  output logic      supply_low,
  output logic      brownout_low,
  output logic      reset_pin,
  output logic      watchdog_expire
);
  logic [3:0] act;

  // Supply starts below level, as at a real power-up
  initial
  begin
    act = 4'h1;
  end

  // One bit per source; the pin is active low
  assign supply_low      = act[0];
  assign brownout_low    = act[1];
  assign reset_pin       = ~act[2];
  assign watchdog_expire = act[3];

  // Hold one source active for n cycles; n of 1 gives a single-cycle pulse
  task automatic pulse(input int sel, input int n);
    @(posedge clk);
    act <= act | (4'h1 << sel);
    repeat (n) @(posedge clk);
    act <= act & ~(4'h1 << sel);
  endtask
endmodule

`default_nettype wire

// ### bench/tb_rsq_sequencer.sv
// Self-checking bench for the reset sequencer.
// Assumes rsq_partner drives the sources; stretch fuse 0 gives 16 cycles.
`timescale 1ns/1ns
`default_nettype none

module tb_rsq_sequencer
  import rsq_pkg::*;
;
  logic       clk;
  logic       rst_n;
  logic [2:0] bod_sel;
  logic       pin_en;
  logic       wd_en;
  logic [1:0] sts;
  rsq_bus_t   bus;
  logic [7:0] rdata;
  logic       core_reset;
  logic       port_reset;
  logic       supply_low;
  logic       brownout_low;
  logic       reset_pin;
  logic       watchdog_expire;
  int         n_fail;
  int         checks;

  rsq_partner ptn_u (.clk(clk), .supply_low(supply_low),
    .brownout_low(brownout_low), .reset_pin(reset_pin),
    .watchdog_expire(watchdog_expire));

  rsq_sequencer dut_u (.clk(clk), .rst_n(rst_n), .supply_low(supply_low),
    .brownout_low(brownout_low), .brownout_level_select(bod_sel),
    .reset_pin(reset_pin), .pin_reset_enable(pin_en),
    .watchdog_expire(watchdog_expire), .watchdog_enable(wd_en),
    .startup_time_select(sts), .clock_source_select(4'h1), .bus(bus),
    .rdata(rdata), .core_reset(core_reset), .port_reset(port_reset));

  // 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic final_report;
    $display("Checks %0d, failures %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Read strobe one cycle; data stands only in the following cycle
  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 chk8(rdata, exp);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  // core_reset must reach v no sooner than lo and no later than hi cycles
  task automatic wait_core(input logic v, input int lo, input int hi);
    int i;
    #1;
    for (i = 0; i < hi && core_reset !== v; i++)
      @(posedge clk) #1;
    chk8({7'h00, core_reset === v && i >= lo}, 8'h01);
  endtask

  // core_reset must stay at v for n cycles
  task automatic hold_core(input logic v, input int n);
    repeat (n)
    begin
      #1 chk8({7'h00, core_reset}, {7'h00, v});
      @(posedge clk);
    end
  endtask

  // Source pulse with the port reset checked in its first cycle
  task automatic fire(input int sel, input int n);
    fork
      ptn_u.pulse(sel, n);
      begin
        @(posedge clk);
        #1 chk8({7'h00, port_reset}, 8'h01);
      end
    join
  endtask

  // Watchdog: generous bound over the expected few thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    final_report();
  end

  initial
  begin
    rst_n = 1'b0;
    bod_sel = 3'h7;
    pin_en = 1'b1;
    wd_en = 1'b1;
    sts = 2'h0;
    bus = '0;
    n_fail = 0;
    checks = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    hold_core(1'b1, 10);
    ptn_u.pulse(0, 1);
    wait_core(1'b0, 16, 40);
    rdchk(4'h1, 8'h02);
    rdchk(4'h0, 8'h01);
    chk8({7'h00, port_reset}, 8'h00);
    wr(4'h0, 8'h00);
    rdchk(4'h0, 8'h00);
    rdchk(4'hF, 8'h00);
    ptn_u.pulse(2, 3);
    hold_core(1'b0, 20);
    pin_en <= 1'b0;
    ptn_u.pulse(2, 30);
    hold_core(1'b0, 10);
    pin_en <= 1'b1;
    fire(2, 30);
    wait_core(1'b1, 0, 1);
    wait_core(1'b0, 16, 40);
    rdchk(4'h0, 8'h02);
    ptn_u.pulse(3, 1);
    wait_core(1'b1, 0, 4);
    wait_core(1'b0, 16, 40);
    rdchk(4'h0, 8'h0A);
    wd_en <= 1'b0;
    ptn_u.pulse(3, 1);
    hold_core(1'b0, 10);
    wd_en <= 1'b1;
    sts <= 2'h1;
    ptn_u.pulse(3, 1);
    wait_core(1'b1, 0, 4);
    wait_core(1'b0, 4096, 4200);
    sts <= 2'h0;
    fire(2, 30);
    repeat (5) @(posedge clk);
    fire(2, 30);
    wait_core(1'b0, 16, 40);
    ptn_u.pulse(1, 200);
    hold_core(1'b0, 10);
    // Every enabling level code, each with a short dip that must be ignored
    for (int c = 0; c < 7; c++)
    begin
      bod_sel <= c[2:0];
      ptn_u.pulse(1, 50);
      hold_core(1'b0, 10);
      ptn_u.pulse(1, 150);
      wait_core(1'b1, 0, 1);
      wait_core(1'b0, 16, 40);
    end
    rdchk(4'h0, 8'h0E);
    rdchk(4'h1, 8'h06);
    fire(0, 5);
    wait_core(1'b1, 0, 4);
    wait_core(1'b0, 16, 40);
    rdchk(4'h0, 8'h01);
    final_report();
  end
endmodule

`default_nettype wire
